// ==== logic/seap_regs.svh ====
/*
 Offsets, field positions, reset values and timing counts of the EEPROM
 access port. Assumes a 50 MHz system clock and a 12-bit config offset.
*/
// What this block does
// - Writing one to the start bit in the idle state launches one EEPROM cycle with current fields.
// - Autoload status bit 4 is one only after a successful autoload.
// - Bit 5 one suppresses autoload; zero keeps it enabled.
// - Clock-rate field 7:6 is stored and read back; every code divides the EEPROM clock by four.
// - Bits 15:8 show the EEPROM's own status byte, read only.
// - Command field 23:16 picks the operation issued on start.
// - Bit 31 selects capacity class: one means larger than 64K.
// - EEPROM location comes from address-and-data bits 15:0.
// - Bits 31:16 supply write data and receive read data.
// - Control sits at offset 87Ch, address-and-data at 880h.
`ifndef SEAP_REGS_SVH
`define SEAP_REGS_SVH

`define SEAP_CTRL_OFF 12'h87C
`define SEAP_DATA_OFF 12'h880

`define SEAP_START_BIT 0
`define SEAP_ALSTAT_BIT 4
`define SEAP_ALDIS_BIT 5
`define SEAP_RATE_LSB 6
`define SEAP_STATUS_LSB 8
`define SEAP_CMD_LSB 16
`define SEAP_SIZE_BIT 31
`define SEAP_ADDR_LSB 0
`define SEAP_WORD_LSB 16

`define SEAP_RATE_RST 2'h1
`define SEAP_RATE_DIV4 2'h1

`define SEAP_CMD_WRSR 8'h01
`define SEAP_CMD_WRITE 8'h02
`define SEAP_CMD_READ 8'h03
`define SEAP_CMD_WRDI 8'h04
`define SEAP_CMD_RDSR 8'h05
`define SEAP_CMD_WREN 8'h06
`define SEAP_CMD_ERASE 8'hC7

`define SEAP_DIV_RATIO 4
`define SEAP_CLK_PERIOD_NS 20
`define SEAP_AL_DELAY_NS 10000
`define SEAP_AL_DELAY_CYC ((`SEAP_AL_DELAY_NS + `SEAP_CLK_PERIOD_NS - 1) / `SEAP_CLK_PERIOD_NS)

`endif

// ==== logic/seap_pkg.sv ====
/*
 Types shared by the EEPROM access port. Assumes the constants header
 supplies all numbers.
*/
package seap_pkg;
   typedef enum logic [1:0] {
      SEAP_ST_WAIT = 2'b00,
      SEAP_ST_AUTO = 2'b01,
      SEAP_ST_IDLE = 2'b10,
      SEAP_ST_RUN = 2'b11
   } seap_state_e;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } seap_cfg_req_s;
endpackage

// ==== logic/seap_shift.sv ====
/*
 Serial shifter for the EEPROM pins, mode 0, MSB first.
 Assumes start only while not busy and a half period of at least one clock.
*/
`timescale 1ns/1ps
module seap_shift #(
   parameter int TXW = 48
) (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire logic start_in,
   input wire logic [5:0] nbits_in,
   input wire logic [TXW-1:0] tx_in,
   input wire logic [3:0] half_in,
   input wire logic miso_in,
   output logic busy_out,
   output logic done_out,
   output logic [15:0] rx_out,
   output logic sck_out,
   output logic cs_n_out,
   output logic mosi_out
);
   logic busy_reg, busy_next, done_reg, done_next, sck_reg, sck_next;
   logic cs_n_reg, cs_n_next, mosi_reg, mosi_next;
   logic [3:0] cnt_reg, cnt_next;
   logic [5:0] left_reg, left_next;
   logic [TXW-1:0] sh_reg, sh_next;
   logic [15:0] rx_reg, rx_next;

   always_comb begin
      busy_next = busy_reg;
      done_next = 1'b0;
      sck_next = sck_reg;
      cs_n_next = cs_n_reg;
      mosi_next = mosi_reg;
      cnt_next = cnt_reg;
      left_next = left_reg;
      sh_next = sh_reg;
      rx_next = rx_reg;
      if (!busy_reg) begin
         if (start_in) begin
            busy_next = 1'b1;
            cs_n_next = 1'b0;
            sck_next = 1'b0;
            cnt_next = 4'h0;
            left_next = nbits_in;
            sh_next = tx_in;
            mosi_next = tx_in[TXW-1];
         end
      end else if (cnt_reg == half_in - 4'h1) begin
         cnt_next = 4'h0;
         if (!sck_reg) begin
            // Sample on the rising edge, the part drives on falling
            sck_next = 1'b1;
            rx_next = {rx_reg[14:0], miso_in};
         end else begin
            sck_next = 1'b0;
            left_next = left_reg - 6'h01;
            sh_next = {sh_reg[TXW-2:0], 1'b0};
            mosi_next = sh_reg[TXW-2];
            if (left_reg == 6'h01) begin
               busy_next = 1'b0;
               cs_n_next = 1'b1;
               mosi_next = 1'b0;
               done_next = 1'b1;
            end
         end
      end else begin
         cnt_next = cnt_reg + 4'h1;
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         sck_reg <= 1'b0;
         cs_n_reg <= 1'b1;
         mosi_reg <= 1'b0;
         cnt_reg <= 4'h0;
         left_reg <= 6'h00;
         sh_reg <= '0;
         rx_reg <= 16'h0000;
      end else begin
         busy_reg <= busy_next;
         done_reg <= done_next;
         sck_reg <= sck_next;
         cs_n_reg <= cs_n_next;
         mosi_reg <= mosi_next;
         cnt_reg <= cnt_next;
         left_reg <= left_next;
         sh_reg <= sh_next;
         rx_reg <= rx_next;
      end
   end

   assign busy_out = busy_reg;
   assign done_out = done_reg;
   assign rx_out = rx_reg;
   assign sck_out = sck_reg;
   assign cs_n_out = cs_n_reg;
   assign mosi_out = mosi_reg;
endmodule

// ==== logic/seap_top.sv ====
/*
 EEPROM access port of the upstream port: control and address-and-data
 registers, autoload after reset and a serial EEPROM engine.
 Assumes config accesses arrive as single-cycle requests on the system clock.
*/
`timescale 1ns/1ps
`include "seap_regs.svh"
module seap_top #(
   parameter int AL_DELAY_CYC = `SEAP_AL_DELAY_CYC,
   // Arbitrary value, chosen only to mark a programmed part
   parameter logic [15:0] AL_SIGNATURE = 16'h5AA5
) (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire seap_pkg::seap_cfg_req_s cfg_req_in,
   output logic [31:0] cfg_rdata_out,
   output logic cfg_rvalid_out,
   output logic eeprom_sck_out,
   output logic eeprom_cs_n_out,
   output logic eeprom_mosi_out,
   input wire logic eeprom_miso_in
);
   localparam int TXW = 48;

   seap_pkg::seap_state_e state_reg, state_next;
   logic start_reg, start_next;
   logic al_ok_reg, al_ok_next;
   logic al_dis_reg, al_dis_next;
   logic [1:0] rate_reg, rate_next;
   logic [7:0] status_reg, status_next;
   logic [7:0] cmd_reg, cmd_next;
   logic size_reg, size_next;
   logic [15:0] addr_reg, addr_next;
   logic [15:0] word_reg, word_next;
   logic [7:0] run_cmd_reg, run_cmd_next;
   logic [15:0] wait_reg, wait_next;
   logic [31:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;

   logic [31:0] ctrl_val, data_val, ctrl_wr, data_wr;
   logic wr_ctrl, wr_data;
   logic sh_start, sh_busy, sh_done;
   logic [5:0] sh_nbits;
   logic [TXW-1:0] sh_tx;
   logic [15:0] sh_rx;
   logic [3:0] sh_half;
   logic [7:0] go_cmd;
   logic [15:0] go_addr;
   logic [23:0] addr_wide;
   logic [5:0] addr_bits;
   logic go_size;

   always_comb begin
      ctrl_val = 32'h0000_0000;
      ctrl_val[`SEAP_START_BIT] = start_reg;
      ctrl_val[`SEAP_ALSTAT_BIT] = al_ok_reg;
      ctrl_val[`SEAP_ALDIS_BIT] = al_dis_reg;
      ctrl_val[`SEAP_RATE_LSB +: 2] = rate_reg;
      ctrl_val[`SEAP_STATUS_LSB +: 8] = status_reg;
      ctrl_val[`SEAP_CMD_LSB +: 8] = cmd_reg;
      ctrl_val[`SEAP_SIZE_BIT] = size_reg;
      data_val = {word_reg, addr_reg};
   end

   // Byte enables merge written lanes with current contents
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         ctrl_wr[8*i +: 8] = cfg_req_in.be[i] ? cfg_req_in.wdata[8*i +: 8] : ctrl_val[8*i +: 8];
         data_wr[8*i +: 8] = cfg_req_in.be[i] ? cfg_req_in.wdata[8*i +: 8] : data_val[8*i +: 8];
      end
   end

   assign wr_ctrl = cfg_req_in.wr && (cfg_req_in.addr == `SEAP_CTRL_OFF);
   assign wr_data = cfg_req_in.wr && (cfg_req_in.addr == `SEAP_DATA_OFF);

   // Command frame: opcode, then address, then data
   // Start sees the command and size written in the same access
   always_comb begin
      go_cmd = `SEAP_CMD_READ;
      go_size = size_reg;
      if (state_reg == seap_pkg::SEAP_ST_IDLE) begin
         go_cmd = wr_ctrl ? ctrl_wr[`SEAP_CMD_LSB +: 8] : cmd_reg;
         go_size = wr_ctrl ? ctrl_wr[`SEAP_SIZE_BIT] : size_reg;
      end
      go_addr = (state_reg == seap_pkg::SEAP_ST_IDLE) ? addr_reg : 16'h0000;
      addr_wide = {8'h00, go_addr};
      addr_bits = go_size ? 6'd24 : 6'd16;
      sh_tx = '0;
      sh_nbits = 6'd8;
      sh_tx[TXW-1 -: 8] = go_cmd;
      unique case (go_cmd)
         `SEAP_CMD_READ, `SEAP_CMD_WRITE: begin
            sh_nbits = 6'd24 + addr_bits;
            if (go_size) begin
               sh_tx[TXW-9 -: 40] = {addr_wide, word_reg};
            end else begin
               sh_tx[TXW-9 -: 32] = {go_addr, word_reg};
            end
         end
         `SEAP_CMD_WRSR, `SEAP_CMD_RDSR: begin
            sh_nbits = 6'd16;
            sh_tx[TXW-9 -: 8] = word_reg[7:0];
         end
         default: begin
            sh_nbits = 6'd8;
         end
      endcase
   end

   // Reserved rate codes fall back to divide by four
   always_comb begin
      sh_half = 4'(`SEAP_DIV_RATIO / 2);
      if (rate_reg != `SEAP_RATE_DIV4) begin
         sh_half = 4'(`SEAP_DIV_RATIO / 2);
      end
   end

   always_comb begin
      state_next = state_reg;
      start_next = start_reg;
      al_ok_next = al_ok_reg;
      al_dis_next = al_dis_reg;
      rate_next = rate_reg;
      status_next = status_reg;
      cmd_next = cmd_reg;
      size_next = size_reg;
      addr_next = addr_reg;
      word_next = word_reg;
      run_cmd_next = run_cmd_reg;
      wait_next = wait_reg;
      sh_start = 1'b0;
      if (wr_ctrl) begin
         al_dis_next = ctrl_wr[`SEAP_ALDIS_BIT];
         rate_next = ctrl_wr[`SEAP_RATE_LSB +: 2];
         cmd_next = ctrl_wr[`SEAP_CMD_LSB +: 8];
         size_next = ctrl_wr[`SEAP_SIZE_BIT];
      end
      if (wr_data) begin
         addr_next = data_wr[`SEAP_ADDR_LSB +: 16];
         word_next = data_wr[`SEAP_WORD_LSB +: 16];
      end
      unique case (state_reg)
         seap_pkg::SEAP_ST_WAIT: begin
            // Grace period lets software suppress autoload first
            if (wait_reg == 16'(AL_DELAY_CYC)) begin
               if (al_dis_next) begin
                  state_next = seap_pkg::SEAP_ST_IDLE;
               end else begin
                  sh_start = 1'b1;
                  state_next = seap_pkg::SEAP_ST_AUTO;
               end
            end else begin
               wait_next = wait_reg + 16'h0001;
            end
         end
         seap_pkg::SEAP_ST_AUTO: begin
            if (sh_done) begin
               al_ok_next = (sh_rx == AL_SIGNATURE);
               state_next = seap_pkg::SEAP_ST_IDLE;
            end
         end
         seap_pkg::SEAP_ST_IDLE: begin
            if (wr_ctrl && ctrl_wr[`SEAP_START_BIT] && !sh_busy) begin
               start_next = 1'b1;
               sh_start = 1'b1;
               run_cmd_next = ctrl_wr[`SEAP_CMD_LSB +: 8];
               state_next = seap_pkg::SEAP_ST_RUN;
            end
         end
         seap_pkg::SEAP_ST_RUN: begin
            // Completion beats a software write to the same fields
            if (sh_done) begin
               start_next = 1'b0;
               state_next = seap_pkg::SEAP_ST_IDLE;
               if (run_cmd_reg == `SEAP_CMD_READ) begin
                  word_next = sh_rx;
               end
               if (run_cmd_reg == `SEAP_CMD_RDSR) begin
                  status_next = sh_rx[7:0];
               end
            end
         end
      endcase
   end

   // Read data stands one cycle; unmapped offsets answer zero
   always_comb begin
      rvalid_next = cfg_req_in.rd;
      rdata_next = 32'h0000_0000;
      if (cfg_req_in.rd && cfg_req_in.addr == `SEAP_CTRL_OFF) begin
         rdata_next = ctrl_val;
      end else if (cfg_req_in.rd && cfg_req_in.addr == `SEAP_DATA_OFF) begin
         rdata_next = data_val;
      end
   end

   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state_reg <= seap_pkg::SEAP_ST_WAIT;
         start_reg <= 1'b0;
         al_ok_reg <= 1'b0;
         al_dis_reg <= 1'b0;
         rate_reg <= `SEAP_RATE_RST;
         status_reg <= 8'h00;
         cmd_reg <= 8'h00;
         size_reg <= 1'b0;
         addr_reg <= 16'h0000;
         word_reg <= 16'h0000;
         run_cmd_reg <= 8'h00;
         wait_reg <= 16'h0000;
         rdata_reg <= 32'h0000_0000;
         rvalid_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         start_reg <= start_next;
         al_ok_reg <= al_ok_next;
         al_dis_reg <= al_dis_next;
         rate_reg <= rate_next;
         status_reg <= status_next;
         cmd_reg <= cmd_next;
         size_reg <= size_next;
         addr_reg <= addr_next;
         word_reg <= word_next;
         run_cmd_reg <= run_cmd_next;
         wait_reg <= wait_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   seap_shift #(
      .TXW(TXW)
   ) u_shift (
      .clk_sys_in(clk_sys_in),
      .resetn_in(resetn_in),
      .start_in(sh_start),
      .nbits_in(sh_nbits),
      .tx_in(sh_tx),
      .half_in(sh_half),
      .miso_in(eeprom_miso_in),
      .busy_out(sh_busy),
      .done_out(sh_done),
      .rx_out(sh_rx),
      .sck_out(eeprom_sck_out),
      .cs_n_out(eeprom_cs_n_out),
      .mosi_out(eeprom_mosi_out)
   );

   assign cfg_rdata_out = rdata_reg;
   assign cfg_rvalid_out = rvalid_reg;
endmodule

// ==== testbench/seap_top_chk.sv ====
/* Assertions on the EEPROM access port.
 Assumes it is bound to seap_top and sees only its ports. */
`timescale 1ns/1ps
module seap_top_chk (
   input wire logic clk_sys_in,
   input wire logic resetn_in,
   input wire seap_pkg::seap_cfg_req_s cfg_req_in,
   input wire logic [31:0] cfg_rdata_out,
   input wire logic cfg_rvalid_out,
   input wire logic eeprom_sck_out,
   input wire logic eeprom_cs_n_out,
   input wire logic eeprom_mosi_out,
   input wire logic eeprom_miso_in
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   logic idle_reg;
   logic [5:0] rises_reg;
   wire ctl_rd = cfg_req_in.rd && cfg_req_in.addr == 12'h87C;
   // Idle only known once the autoload frame has closed
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         idle_reg <= 1'b0;
         rises_reg <= 6'h0;
      end else begin
         if ($rose(eeprom_cs_n_out)) idle_reg <= 1'b1;
         if (eeprom_cs_n_out) rises_reg <= 6'h0;
         else if ($rose(eeprom_sck_out)) rises_reg <= rises_reg + 6'h1;
      end
   end
   property p_rvalid; 1 |=> cfg_rvalid_out == $past(cfg_req_in.rd); endproperty
   a_rvalid: assert property (p_rvalid) else $error("read answer timing wrong");
   property p_unmapped; cfg_req_in.rd && !(cfg_req_in.addr inside {12'h87C, 12'h880}) |=> cfg_rdata_out == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_rsvd; ctl_rd |=> cfg_rdata_out[3:1] == 3'h0 && cfg_rdata_out[30:24] == 7'h0; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved control bits not zero");
   property p_sck_high; $rose(eeprom_sck_out) |=> eeprom_sck_out ##1 !eeprom_sck_out; endproperty
   a_sck_high: assert property (p_sck_high) else $error("clock high phase not two cycles");
   property p_sck_low; $fell(eeprom_sck_out) && !eeprom_cs_n_out |=> !eeprom_sck_out ##1 eeprom_sck_out; endproperty
   a_sck_low: assert property (p_sck_low) else $error("clock low phase not two cycles");
   property p_idle; eeprom_cs_n_out |-> !eeprom_sck_out && !eeprom_mosi_out; endproperty
   a_idle: assert property (p_idle) else $error("serial lines not idle outside frame");
   property p_start; cfg_req_in.wr && cfg_req_in.addr == 12'h87C && cfg_req_in.be[0] && cfg_req_in.wdata[0]
      && idle_reg && eeprom_cs_n_out && $past(eeprom_cs_n_out) |=> !eeprom_cs_n_out; endproperty
   a_start: assert property (p_start) else $error("start did not open a frame");
   property p_frame; $rose(eeprom_cs_n_out) |-> rises_reg inside {6'd8, 6'd16, 6'd40, 6'd48}; endproperty
   a_frame: assert property (p_frame) else $error("frame length illegal");
   property p_busy; ctl_rd && idle_reg && !eeprom_cs_n_out |=> cfg_rdata_out[0]; endproperty
   a_busy: assert property (p_busy) else $error("start bit low during frame");
   property p_clear; $rose(eeprom_cs_n_out) ##[1:3] ctl_rd |=> !cfg_rdata_out[0]; endproperty
   a_clear: assert property (p_clear) else $error("start bit not cleared after frame");
endmodule
bind seap_top seap_top_chk u_chk (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .cfg_req_in(cfg_req_in),
   .cfg_rdata_out(cfg_rdata_out), .cfg_rvalid_out(cfg_rvalid_out), .eeprom_sck_out(eeprom_sck_out),
   .eeprom_cs_n_out(eeprom_cs_n_out), .eeprom_mosi_out(eeprom_mosi_out), .eeprom_miso_in(eeprom_miso_in));

// ==== testbench/seap_eeprom_model.sv ====
/* Behavioural serial EEPROM, mode 0, MSB first; records each frame.
 Assumes the bench sets read word, status byte and address width. */
`timescale 1ns/1ps
module seap_eeprom_model (
   input wire logic sck_in,
   input wire logic cs_n_in,
   input wire logic mosi_in,
   input wire logic wide_in,
   input wire logic [15:0] word_in,
   input wire logic [7:0] status_in,
   output logic miso_out,
   output logic [7:0] frames_out,
   output logic [5:0] nbits_out,
   output logic [47:0] frame_out
);
   logic [47:0] sr = '0;
   logic [7:0] op = '0;
   logic [5:0] cnt = '0;
   int ab;
   int i;
   initial miso_out = 1'b0;
   initial frames_out = 8'h0;
   always @(negedge cs_n_in) begin
      sr = '0;
      cnt = '0;
      op = '0;
   end
   always @(posedge sck_in) if (!cs_n_in) begin
      sr = {sr[46:0], mosi_in};
      cnt = cnt + 6'd1;
      if (cnt == 6'd8) op = sr[7:0];
   end
   always @(posedge cs_n_in) begin
      frame_out = sr;
      nbits_out = cnt;
      frames_out = frames_out + 8'd1;
   end
   // Outside the answer phase the line toggles, so a stale bit never matches
   always @(negedge sck_in or cs_n_in) begin
      ab = wide_in ? 32 : 24;
      i = int'(cnt);
      if (!cs_n_in && op == 8'h03 && i >= ab && i < ab + 16) miso_out = word_in[15 - (i - ab)];
      else if (!cs_n_in && op == 8'h05 && i >= 8 && i < 16) miso_out = status_in[15 - i];
      else miso_out = ~miso_out;
   end
endmodule

// ==== testbench/testbench.sv ====
/* Self-checking bench of the EEPROM access port with an EEPROM model.
 Assumes design, checker and model are compiled first. */
`timescale 1ns/1ps
module testbench;
   localparam logic [15:0] SIG = 16'h3C96; // Arbitrary marker value
   logic clk_sys_in = 1'b0;
   logic resetn_in = 1'b0;
   seap_pkg::seap_cfg_req_s req = '0;
   logic [31:0] rdata, d;
   logic rvalid, sck, cs_n, mosi, miso, wide = 1'b0;
   logic [15:0] word = SIG;
   logic [7:0] stat = 8'h0, frames;
   logic [5:0] nbits;
   logic [47:0] frame, exp;
   int fails = 0, samples_checked = 0;
   always #10 clk_sys_in = ~clk_sys_in;
   seap_top #(.AL_DELAY_CYC(4), .AL_SIGNATURE(SIG)) dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .cfg_req_in(req), .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid), .eeprom_sck_out(sck),
      .eeprom_cs_n_out(cs_n), .eeprom_mosi_out(mosi), .eeprom_miso_in(miso));
   seap_eeprom_model model (.sck_in(sck), .cs_n_in(cs_n), .mosi_in(mosi), .wide_in(wide), .word_in(word),
      .status_in(stat), .miso_out(miso), .frames_out(frames), .nbits_out(nbits), .frame_out(frame));
   task automatic give_verdict;
      if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp(input logic [47:0] got, input logic [47:0] want);
      samples_checked++;
      if (got !== want) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, want);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge clk_sys_in) req <= '{1'b1, 1'b0, a, 4'hF, v};
      @(posedge clk_sys_in) req <= '0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge clk_sys_in) req <= '{1'b0, 1'b1, a, 4'hF, 32'h0};
      @(posedge clk_sys_in) req <= '0;
      @(posedge clk_sys_in) d = rdata;
      cmp(rvalid, 1'b1);
   endtask
   task automatic wait_done;
      for (int i = 0; i < 200; i++) begin
         rd(12'h87C);
         if (d[0] === 1'b0) return;
      end
      fails++;
      give_verdict;
   endtask
   task automatic wait_frame(input logic [7:0] f);
      for (int i = 0; i < 400; i++) begin
         @(posedge clk_sys_in);
         if (frames !== f) return;
      end
      fails++;
      give_verdict;
   endtask
   task automatic do_reset(input logic [15:0] w);
      word = w;
      // Autoload runs in small-capacity mode after reset unless bit 31 is set during the grace period
      wide = 1'b0;
      resetn_in <= 1'b0;
      repeat (20) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
   endtask
   function automatic logic [47:0] exp_frame(input logic [7:0] c, input logic [15:0] a, input logic [15:0] v,
      output int n, output int skip);
      skip = 0;
      n = 8;
      exp_frame = {40'h0, c};
      if (c == 8'h02 || c == 8'h03) begin
         n = wide ? 48 : 40;
         exp_frame = wide ? {c, 8'h00, a, v} : {8'h0, c, a, v};
         if (c == 8'h03) skip = 16;
      end else if (c == 8'h01 || c == 8'h05) begin
         n = 16;
         skip = (c == 8'h05) ? 8 : 0;
         exp_frame = {32'h0, c, v[7:0]};
      end
   endfunction
   initial begin
      logic [7:0] c, f0, st, lb;
      logic [15:0] a, v;
      int n, skip;
      logic [7:0] cmds [8];
      cmds = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'hC7, 8'h9A};
      void'($urandom(32'h75998e18));
      st = 8'h0;
      do_reset(SIG);
      f0 = frames;
      wait_frame(f0);
      cmp(frame >> 16, {8'h03, 16'h0});
      rd(12'h87C);
      cmp(d, 32'h50);
      for (int i = 0; i < 16; i++) begin
         c = cmds[i % 8];
         a = $urandom;
         v = $urandom;
         wide = i[3];
         word = $urandom;
         stat = $urandom;
         // Reserved rate code 11b must still divide by four
         lb = i[2] ? 8'hC1 : 8'h41;
         f0 = frames;
         wr(12'h880, {v, a});
         wr(12'h87C, {wide, 7'h0, c, 8'h0, lb});
         // Second start while busy must be dropped, its command kept
         if (i == 5) wr(12'h87C, {wide, 7'h0, 8'h04, 8'h0, lb});
         wait_done;
         exp = exp_frame(c, a, v, n, skip);
         cmp(frame >> skip, exp >> skip);
         cmp(nbits, n);
         cmp(frames, 8'(f0 + 8'h1));
         if (c == 8'h05) st = stat;
         rd(12'h880);
         cmp(d, {(c == 8'h03) ? word : v, a});
         rd(12'h87C);
         cmp(d, {wide, 7'h0, (i == 5) ? 8'h04 : c, st, lb[7:6], 6'h10});
      end
      wr(12'h884, 32'hFFFFFFFF);
      rd(12'h884);
      cmp(d, 32'h0);
      do_reset(~SIG);
      f0 = frames;
      wait_frame(f0);
      rd(12'h87C);
      cmp(d, 32'h40);
      do_reset(SIG);
      f0 = frames;
      wr(12'h87C, 32'h60);
      repeat (20) @(posedge clk_sys_in);
      cmp(frames, f0);
      rd(12'h87C);
      cmp(d, 32'h60);
      rd(12'h880);
      cmp(d, 32'h0);
      give_verdict;
   end
endmodule
